// ===== src/swd_ctrl.sv
// Sleep mode, watchdog and option control for a small controller core.
// Assumes a core that presents each executed opcode with a one-cycle
// strobe, an interrupt controller that reports a serviced request, and
// a supply monitor level; all are on clk unless named as a pin.
//
// The implementer's own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/100ps

module swd_ctrl
  import swd_pkg::*;
#(
  parameter int unsigned WDT_PERIOD_CYC = 32'd20000,
  parameter int unsigned POR_DELAY_CYC  = 32'd10000
)(
  input  wire logic       clk,
  input  wire logic       nrst,
  // Opcode strobe from the core
  input  wire logic       op_valid,
  input  wire logic [7:0] op_code,
  // Interrupt controller reports a serviced enabled request
  input  wire logic       irq_serviced,
  // Pins and monitor
  input  wire logic       stop_recovery_input,
  input  wire logic       supply_low,
  // Avalon-MM slave
  input  wire logic [3:0] avs_address,
  input  wire logic       avs_read,
  input  wire logic       avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0] avs_byteenable,
  output logic [31:0]     avs_readdata,
  output logic            avs_waitrequest,
  output logic [1:0]      avs_response,
  // Outputs toward the core and pads
  output logic            cpu_clk_en,
  output logic            osc_en,
  output logic            rc_osc_sel,
  output logic            xtal_en,
  output logic            osc32k_sel,
  output logic            div2_bypass,
  output logic            sys_clk_tick,
  output logic            timer_clock,
  output logic            irq_a_d_active,
  output logic            ext_read_block,
  output logic            prog_load_allow,
  output logic            auto_latch_en,
  output logic            sys_reset_n,
  output logic            pc_load,
  output logic [15:0]     pc_vector,
  output logic            flag_write,
  output logic            flag_z,
  output logic            flag_s,
  output logic            flag_v,
  output logic [7:0]      port2_direction_reg
);

  //////////////////////////////////////////////////////////////////////////
  // Derived counts
  localparam logic [31:0] WDT_LIM = 32'(WDT_PERIOD_CYC);
  localparam logic [31:0] RST_LIM =
    32'(POR_DELAY_CYC) + 32'(WDT_EXTRA_CYC);

  // Bus response codes
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Register address decode
  function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
    hit = (a == r);
  endfunction

  // Whole module state
  typedef struct packed {
    swd_mode_t       mode;
    logic [2:0]      rec_sync;
    logic            rec_low;
    logic [2:0]      lv_sync;
    logic            lv_low;
    logic            wdt_on;
    logic            wdt_halt;
    logic [31:0]     wdt_cnt;
    logic [31:0]     rst_cnt;
    logic            rst_act;
    logic            perm_done;
    logic [CTL_W-1:0] ctl;
    logic [7:0]      p2dir;
    logic [3:0]      div_cnt;
    logic            tick;
    logic            ack;
    logic [31:0]     rdata;
    logic [1:0]      resp;
    logic            pc_ld;
    logic            fl_wr;
  } swd_state_t;

  swd_state_t s_q;
  swd_state_t s_d;

  logic wdt_run;
  logic wdt_tmo;
  logic op_ok;

  //////////////////////////////////////////////////////////////////////////
  // Watchdog gating by mode
  always_comb
  begin
    op_ok   = op_valid && (s_q.mode == SWD_RUN) && !s_q.rst_act;
    wdt_run = s_q.wdt_on && !s_q.rst_act;
    if (s_q.ctl[CTL_PERM_WDT])
      wdt_run = !s_q.rst_act;
    else if (s_q.mode == SWD_STOP)
      wdt_run = 1'b0;
    else if (s_q.mode == SWD_HALT && !s_q.wdt_halt)
      wdt_run = 1'b0;
    wdt_tmo = wdt_run && (s_q.wdt_cnt >= WDT_LIM - 32'd1);
  end

  //////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    s_d       = s_q;
    s_d.pc_ld = 1'b0;
    s_d.fl_wr = 1'b0;
    s_d.ack   = 1'b0;

    // Pin and monitor synchronisers; change once stages two and three agree
    // Only the shift reads stage one, so a metastable first flop never
    // reaches the mode logic; a one-cycle glitch is filtered out too.
    s_d.rec_sync = {s_q.rec_sync[1:0], stop_recovery_input};
    if (s_q.rec_sync[2] == s_q.rec_sync[1])
      s_d.rec_low = !s_q.rec_sync[2];
    s_d.lv_sync = {s_q.lv_sync[1:0], supply_low};
    if (s_q.lv_sync[2] == s_q.lv_sync[1])
      s_d.lv_low = s_q.lv_sync[2];

    // Clock divider: divide-by-two or low-EMI ceiling
    s_d.tick = 1'b0;
    if (s_q.div_cnt == 4'h0)
    begin
      s_d.tick    = 1'b1;
      s_d.div_cnt = s_q.ctl[CTL_LOW_EMI] ? EMI_DIV_CNT
                                         : STD_DIV_CNT;
    end
    else
      s_d.div_cnt = s_q.div_cnt - 4'h1;

    // Opcode handling and mode sequencing
    case (s_q.mode)
      SWD_RUN:
      begin
        if (op_ok && op_code == OP_HALT)
          s_d.mode = SWD_HALT;
        else if (op_ok && op_code == OP_STOP)
          s_d.mode = SWD_STOP;
      end
      SWD_HALT:
        if (irq_serviced)
          s_d.mode = SWD_RUN;
      SWD_STOP:
        if (s_q.rec_low)
        begin
          s_d.mode  = SWD_RUN;
          s_d.pc_ld = 1'b1;
        end
      default:
        s_d.mode = SWD_RUN;
    endcase

    // Watchdog opcodes; no instruction turns the watchdog off
    if (op_ok && op_code == OP_WDT)
    begin
      s_d.wdt_on = 1'b1;
      s_d.fl_wr  = 1'b1;
    end
    if (op_ok && op_code == OP_WDT_HALT && s_q.wdt_on)
      s_d.wdt_halt = 1'b1;

    // Permanent option arms the watchdog once after reset
    if (!s_q.perm_done && !s_q.rst_act)
    begin
      s_d.perm_done = 1'b1;
      if (s_q.ctl[CTL_PERM_WDT])
        s_d.wdt_on = 1'b1;
    end

    // Watchdog counter
    // A clear in the cycle where the count hits its limit comes too late:
    // the timeout below already fires, so software must clear early.
    if (op_ok && op_code == OP_WDT && s_q.wdt_on)
      s_d.wdt_cnt = '0;
    else if (wdt_run)
      s_d.wdt_cnt = s_q.wdt_cnt + 32'd1;

    // Internal reset: watchdog timeout or low supply
    if (wdt_tmo || s_q.lv_low)
    begin
      s_d.rst_act   = 1'b1;
      s_d.rst_cnt   = '0;
      s_d.mode      = SWD_RUN;
      s_d.wdt_on    = 1'b0;
      s_d.wdt_halt  = 1'b0;
      s_d.wdt_cnt   = '0;
      s_d.perm_done = 1'b0;
      s_d.p2dir     = P2DIR_RESET;
    end
    else if (s_q.rst_act)
    begin
      if (s_q.rst_cnt >= RST_LIM - 32'd1)
        s_d.rst_act = 1'b0;
      else
        s_d.rst_cnt = s_q.rst_cnt + 32'd1;
    end

    // Avalon slave: one wait cycle, answer on the second edge
    if ((avs_read || avs_write) && !s_q.ack)
    begin
      s_d.ack  = 1'b1;
      s_d.resp = RESP_OKAY;
      s_d.rdata = '0;
      if (hit(avs_address, ADDR_CTRL))
      begin
        if (avs_write && avs_byteenable[0])
          s_d.ctl = avs_writedata[CTL_W-1:0];
        s_d.rdata[CTL_W-1:0] = s_q.ctl;
      end
      else if (hit(avs_address, ADDR_STATUS))
        s_d.rdata[7:0] = {2'b00, s_q.rst_act, s_q.wdt_halt,
                          s_q.wdt_on, 1'b0, s_q.mode};
      else if (hit(avs_address, ADDR_P2DIR))
      begin
        // Kept across stop recovery; only reset or software change it
        if (avs_write && avs_byteenable[0])
          s_d.p2dir = avs_writedata[7:0];
        s_d.rdata[7:0] = s_q.p2dir;
      end
      else
        s_d.resp = RESP_SLVERR;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_q          <= '0;
      s_q.mode     <= SWD_RUN;
      s_q.rec_sync <= 3'b111;
      s_q.rst_act  <= 1'b1;
      s_q.p2dir    <= P2DIR_RESET;
      s_q.div_cnt  <= STD_DIV_CNT;
    end
    else
      s_q <= s_d;
  end

  //////////////////////////////////////////////////////////////////////////
  // Bus outputs
  // Waitrequest is combinational so every request stalls one cycle;
  // data and response come from flops set on the taking edge.
  always_comb
  begin
    avs_waitrequest = (avs_read || avs_write) && !s_q.ack;
    avs_readdata    = s_q.rdata;
    avs_response    = s_q.resp;
  end

  //////////////////////////////////////////////////////////////////////////
  // Clock gating by power mode
  // HALT keeps oscillator and timers alive; STOP freezes all but the recovery
  // and supply synchronisers and the permanent watchdog, which run on the free core clock.
  always_comb
  begin
    cpu_clk_en     = (s_q.mode == SWD_RUN);
    osc_en         = (s_q.mode != SWD_STOP);
    irq_a_d_active = (s_q.mode != SWD_STOP);
  end

  //////////////////////////////////////////////////////////////////////////
  // Option bits
  // The slow oscillator loses to the RC option; the crystal runs only
  // when neither alternative is chosen and the part is not stopped.
  always_comb
  begin
    rc_osc_sel      = s_q.ctl[CTL_RC_OSC];
    osc32k_sel      = s_q.ctl[CTL_OSC32K] && !s_q.ctl[CTL_RC_OSC];
    xtal_en         = osc_en && !rc_osc_sel && !osc32k_sel;
    div2_bypass     = s_q.ctl[CTL_LOW_EMI];
    ext_read_block  = s_q.ctl[CTL_PROTECT];
    prog_load_allow = 1'b1;
    auto_latch_en   = !s_q.ctl[CTL_NO_LATCH];
  end

  //////////////////////////////////////////////////////////////////////////
  // Ticks: system tick stops in HALT and STOP, timer tick only in STOP
  always_comb
  begin
    sys_clk_tick = s_q.tick && cpu_clk_en;
    timer_clock  = s_q.tick && osc_en;
  end

  //////////////////////////////////////////////////////////////////////////
  // Core-facing reset, restart and flag outputs
  // Flag values are constants; only the write strobe is timed.
  always_comb
  begin
    sys_reset_n         = !s_q.rst_act;
    pc_load             = s_q.pc_ld;
    pc_vector           = STOP_VECTOR;
    flag_write          = s_q.fl_wr;
    flag_z              = 1'b1;
    flag_s              = 1'b0;
    flag_v              = 1'b0;
    port2_direction_reg = s_q.p2dir;
  end

endmodule // swd_ctrl

// ===== shared/swd_pkg.sv
// Constants and types for the sleep and watchdog control block.
// Assumes a single 20 MHz core clock and an Avalon-MM register master.
package swd_pkg;

  // Clock rate
  localparam int unsigned CLK_HZ = 20000000;

  // Opcodes seen on the fetch strobe
  localparam logic [7:0] OP_NOP  = 8'hFF;
  localparam logic [7:0] OP_STOP = 8'h6F;
  localparam logic [7:0] OP_HALT = 8'h7F;
  localparam logic [7:0] OP_WDT  = 8'h5F;
  localparam logic [7:0] OP_WDT_HALT = 8'h4F;

  // Restart vector after stop recovery
  localparam logic [15:0] STOP_VECTOR = 16'h000C;

  // Reset extension in crystal cycles after the power-on delay
  localparam logic [15:0] WDT_EXTRA_CYC = 16'h0012;

  // Low-EMI clock ceiling and the divider stage
  localparam int unsigned LOW_EMI_MAX_HZ = 4000000;
  localparam logic [3:0] EMI_DIV_CNT =
    4'((CLK_HZ + LOW_EMI_MAX_HZ - 1) / LOW_EMI_MAX_HZ - 1);
  localparam logic [3:0] STD_DIV_CNT = 4'h1;

  // Register byte addresses
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_P2DIR  = 4'h8;

  // Control register fields
  localparam int CTL_LOW_EMI   = 0;
  localparam int CTL_RC_OSC    = 1;
  localparam int CTL_PROTECT   = 2;
  localparam int CTL_NO_LATCH  = 3;
  localparam int CTL_PERM_WDT  = 4;
  localparam int CTL_OSC32K    = 5;
  localparam int CTL_W         = 6;

  // Reset value of the port 2 direction register (all inputs)
  localparam logic [7:0] P2DIR_RESET = 8'hFF;

  // Power modes
  typedef enum logic [1:0] {
    SWD_RUN,
    SWD_HALT,
    SWD_STOP
  } swd_mode_t;

endpackage

// ===== verification/swd_ctrl_checker.sv
// Concurrent checks on the sleep and watchdog control block.
// Assumes one clock domain and the async active-low nrst.
`timescale 1ns/100ps

module swd_ctrl_checker
  import swd_pkg::*;
#(
  parameter int unsigned POR_DELAY_CYC = 32'd10000
)(
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        op_valid,
  input wire logic [7:0]  op_code,
  input wire logic        irq_serviced,
  input wire logic        supply_low,
  input wire logic        cpu_clk_en,
  input wire logic        osc_en,
  input wire logic        xtal_en,
  input wire logic        rc_osc_sel,
  input wire logic        osc32k_sel,
  input wire logic        div2_bypass,
  input wire logic        timer_clock,
  input wire logic        irq_a_d_active,
  input wire logic        sys_reset_n,
  input wire logic        pc_load,
  input wire logic [15:0] pc_vector,
  input wire logic        flag_write,
  input wire logic        flag_z,
  input wire logic        flag_s,
  input wire logic        flag_v
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  int lo_q;

  ////////////////////////////////////////////////////////////
  // Length of the current internal reset
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      lo_q <= 0;
    else
      lo_q <= sys_reset_n ? 0 : lo_q + 1;

  ////////////////////////////////////////////////////////////
  AST_HALT_GATE: assert property (sys_reset_n && cpu_clk_en && op_valid
    && op_code == OP_HALT |=> !cpu_clk_en && osc_en && irq_a_d_active)
    else $error("halt entry wrong");
  AST_HALT_EXIT: assert property (sys_reset_n && !cpu_clk_en && osc_en
    && irq_serviced |=> cpu_clk_en)
    else $error("halt not left");
  AST_STOP_GATE: assert property (sys_reset_n && cpu_clk_en && op_valid
    && op_code == OP_STOP |=> !cpu_clk_en && !osc_en && !xtal_en)
    else $error("stop entry wrong");
  AST_STOP_VEC: assert property (pc_load |-> pc_vector == 16'h000C
    && cpu_clk_en && osc_en)
    else $error("bad restart vector");
  AST_WDT_FLAGS: assert property (sys_reset_n && cpu_clk_en && op_valid
    && op_code == OP_WDT |=> flag_write && flag_z && !flag_s && !flag_v)
    else $error("watchdog flags wrong");
  AST_RST_LEN: assert property ($rose(sys_reset_n) |->
    lo_q >= POR_DELAY_CYC + 17)
    else $error("internal reset too short");
  AST_LOW_SUPPLY: assert property (supply_low [*7] |-> !sys_reset_n)
    else $error("no reset on low supply");
  AST_EMI_TICK: assert property (timer_clock && div2_bypass
    && $past(div2_bypass) |=> !timer_clock [*4])
    else $error("low-emi tick too fast");
  AST_OSC_SEL: assert property ((rc_osc_sel || osc32k_sel) |-> !xtal_en
    && !(rc_osc_sel && osc32k_sel))
    else $error("oscillator select clash");
endmodule // swd_ctrl_checker

bind swd_ctrl swd_ctrl_checker #(.POR_DELAY_CYC(POR_DELAY_CYC)) u_chk (
  .clk            (clk),
  .nrst           (nrst),
  .op_valid       (op_valid),
  .op_code        (op_code),
  .irq_serviced   (irq_serviced),
  .supply_low     (supply_low),
  .cpu_clk_en     (cpu_clk_en),
  .osc_en         (osc_en),
  .xtal_en        (xtal_en),
  .rc_osc_sel     (rc_osc_sel),
  .osc32k_sel     (osc32k_sel),
  .div2_bypass    (div2_bypass),
  .timer_clock    (timer_clock),
  .irq_a_d_active (irq_a_d_active),
  .sys_reset_n    (sys_reset_n),
  .pc_load        (pc_load),
  .pc_vector      (pc_vector),
  .flag_write     (flag_write),
  .flag_z         (flag_z),
  .flag_s         (flag_s),
  .flag_v         (flag_v)
);

// ===== verification/swd_ctrl_tb.sv
// Self-checking bench for the sleep and watchdog control block.
// Assumes the checker is bound; short watchdog and power-on counts.
`timescale 1ns/100ps

module swd_ctrl_tb;
  import swd_pkg::*;

  logic        clk, nrst, op_valid, irq_serviced, stop_recovery_input;
  logic        supply_low, avs_read, avs_write, avs_waitrequest;
  logic        cpu_clk_en, osc_en, rc_osc_sel, xtal_en, osc32k_sel;
  logic        div2_bypass, sys_clk_tick, timer_clock, irq_a_d_active;
  logic        ext_read_block, prog_load_allow, auto_latch_en;
  logic        sys_reset_n, pc_load, flag_write, flag_z, flag_s, flag_v;
  logic [7:0]  op_code, port2_direction_reg;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [1:0]  avs_response, rp;
  logic [15:0] pc_vector;
  int          n_mismatch, cmp_count, c;

  swd_ctrl #(.WDT_PERIOD_CYC(50), .POR_DELAY_CYC(10)) DUT (
    .clk                 (clk),
    .nrst                (nrst),
    .op_valid            (op_valid),
    .op_code             (op_code),
    .irq_serviced        (irq_serviced),
    .stop_recovery_input (stop_recovery_input),
    .supply_low          (supply_low),
    .avs_address         (avs_address),
    .avs_read            (avs_read),
    .avs_write           (avs_write),
    .avs_writedata       (avs_writedata),
    .avs_byteenable      (avs_byteenable),
    .avs_readdata        (avs_readdata),
    .avs_waitrequest     (avs_waitrequest),
    .avs_response        (avs_response),
    .cpu_clk_en          (cpu_clk_en),
    .osc_en              (osc_en),
    .rc_osc_sel          (rc_osc_sel),
    .xtal_en             (xtal_en),
    .osc32k_sel          (osc32k_sel),
    .div2_bypass         (div2_bypass),
    .sys_clk_tick        (sys_clk_tick),
    .timer_clock         (timer_clock),
    .irq_a_d_active      (irq_a_d_active),
    .ext_read_block      (ext_read_block),
    .prog_load_allow     (prog_load_allow),
    .auto_latch_en       (auto_latch_en),
    .sys_reset_n         (sys_reset_n),
    .pc_load             (pc_load),
    .pc_vector           (pc_vector),
    .flag_write          (flag_write),
    .flag_z              (flag_z),
    .flag_s              (flag_s),
    .flag_v              (flag_v),
    .port2_direction_reg (port2_direction_reg)
  );

  ////////////////////////////////////////////////////////////
  // Clock, 50 ns period
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task chk(input string nm, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("Error %s expected %0h seen %0h", nm, e, s);
    end
  endtask

  task conclude;
    $display("Checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Bus cycle held until waitrequest is seen low
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (avs_waitrequest !== 1'b0 && k < 50);
    if (avs_waitrequest !== 1'b0)
      n_mismatch++;
    rd = avs_readdata;
    rp = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task op(input logic [7:0] b);
    @(posedge clk);
    op_valid <= 1'b1;
    op_code <= b;
    @(posedge clk);
    op_valid <= 1'b0;
  endtask

  task wt(input logic v, input int n);
    c = 0;
    while (sys_reset_n !== v && c < n)
    begin
      @(posedge clk);
      c++;
    end
    if (sys_reset_n !== v)
      n_mismatch++;
  endtask

  // Cycles between two system ticks, measured after the divider reloads
  task tgap(output int g);
    g = 0;
    repeat (2)
      do @(posedge clk); while (sys_clk_tick !== 1'b1);
    do
    begin
      @(posedge clk);
      g++;
    end
    while (sys_clk_tick !== 1'b1 && g < 20);
  endtask

  task sleep(input logic [7:0] b);
    op(OP_NOP);
    op(b);
    @(posedge clk);
  endtask

  task wake;
    irq_serviced <= 1'b1;
    @(posedge clk);
    irq_serviced <= 1'b0;
    @(posedge clk);
    chk("wake", cpu_clk_en, 1);
  endtask

  ////////////////////////////////////////////////////////////
  task t_regs;
    logic [5:0] tv [6] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h20, 6'h22};
    bus(0, ADDR_P2DIR, 0);
    chk("p2dir", rd, 32'h0000_00FF);
    bus(0, 4'hC, 0);
    chk("resp", rp, 2'b10);
    foreach (tv[i])
    begin
      bus(1, ADDR_CTRL, {26'h0, tv[i]});
      chk("emi", div2_bypass, tv[i][0]);
      chk("xtal", xtal_en, !tv[i][1] && !tv[i][5]);
      chk("prot", {ext_read_block, prog_load_allow}, {tv[i][2], 1'b1});
      chk("latch", auto_latch_en, !tv[i][3]);
      chk("s32k", osc32k_sel, tv[i][5] && !tv[i][1]);
      chk("rc", rc_osc_sel, tv[i][1]);
      tgap(c);
      chk("tick", c, tv[i][0] ? 5 : 2);
    end
    bus(1, ADDR_CTRL, 0);
  endtask

  task t_sleep;
    sleep(OP_HALT);
    chk("halt", {cpu_clk_en, osc_en, irq_a_d_active}, 3'b011);
    repeat (5) @(posedge clk);
    wake();
    bus(1, ADDR_P2DIR, 32'h7F);
    op(OP_WDT);
    sleep(OP_STOP);
    chk("stop", {cpu_clk_en, osc_en, xtal_en}, 3'b000);
    repeat (100) @(posedge clk);
    chk("wdt_stop", sys_reset_n, 1);
    stop_recovery_input <= 1'b0;
    c = 0;
    while (pc_load !== 1'b1 && c < 10)
    begin
      @(posedge clk);
      c++;
    end
    chk("rec", c < 10, 1);
    chk("vec", pc_vector, STOP_VECTOR);
    stop_recovery_input <= 1'b1;
    op(OP_WDT);
    bus(0, ADDR_P2DIR, 0);
    chk("p2keep", rd, 32'h7F);
    chk("p2pin", port2_direction_reg, 8'h7F);
  endtask

  task watchdog_timeout_period;
    repeat (4)
    begin
      repeat (30) @(posedge clk);
      op(OP_WDT);
      @(posedge clk);
      chk("flags", {flag_write, flag_z, flag_s, flag_v}, 4'hC);
      chk("alive", sys_reset_n, 1);
    end
    wt(0, 60);
    chk("wdt_to", c < 60, 1);
    wt(1, 60);
    chk("rst_len", c inside {[27:29]}, 1);
    bus(0, ADDR_P2DIR, 0);
    chk("p2rst", rd, 32'h0000_00FF);
    op(OP_WDT_HALT);
    op(OP_WDT);
    sleep(OP_HALT);
    repeat (80) @(posedge clk);
    chk("wdh_off", sys_reset_n, 1);
    wake();
    op(OP_WDT);
    sleep(OP_HALT);
    repeat (80) @(posedge clk);
    chk("halt_pause", sys_reset_n, 1);
    wake();
    op(OP_WDT);
    op(OP_WDT_HALT);
    sleep(OP_HALT);
    wt(0, 60);
    chk("wdh_run", c < 60, 1);
    wt(1, 60);
  endtask

  task t_perm;
    bus(1, ADDR_CTRL, 32'h10);
    supply_low <= 1'b1;
    repeat (8) @(posedge clk);
    chk("lv", sys_reset_n, 0);
    supply_low <= 1'b0;
    wt(1, 80);
    sleep(OP_STOP);
    wt(0, 60);
    chk("perm", c < 60, 1);
  endtask

  ////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {nrst, op_valid, irq_serviced, supply_low, avs_read, avs_write} = '0;
    {op_code, avs_address, avs_writedata} = '0;
    stop_recovery_input = 1'b1;
    avs_byteenable = 4'hF;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    wt(1, 100);
    t_regs();
    t_sleep();
    watchdog_timeout_period();
    t_perm();
    conclude();
  end

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    conclude();
  end
endmodule // swd_ctrl_tb
